//--- design/iosd_decoder.sv
`timescale 1ns/100ps
`include "iosd_params.svh"

module iosd_decoder
  import iosd_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input iosd_req_t REQ,
  output iosd_rsp_t RSP,
  output iosd_ext_t EXT,
  input wire logic [7:0] EXT_RDATA,
  input wire logic [6:0][7:0] PIN_IN,
  output logic [6:0][7:0] PORT_OUT,
  output logic [6:0][7:0] DIR_OUT,
  input wire logic [2:0][7:0] TMR_FLAG_SET,
  input wire logic [7:0] EXT_FLAG_SET,
  output logic [2:0][7:0] TMR_FLAG_OUT,
  output logic [7:0] EXT_FLAG_OUT,
  output logic [7:0] EXT_MASK_OUT,
  output logic [7:0] SCRATCH_OUT,
  output logic [7:0] NVM_CTRL_OUT,
  output logic [7:0] NVM_DATA_OUT,
  output logic [15:0] NVM_ADDR_OUT,
  output logic [7:0] PRESCALE_CTRL_OUT,
  output logic [7:0] T0_CTRL_OUT,
  output logic T0_FORCE,
  output logic [7:0] T0_COUNT_OUT
);

  // ========================================================================
  // location table
  function automatic iosd_kind_t entry_kind(input logic [5:0] idx);
    iosd_kind_t k;
    k = IOSD_K_NONE;
    unique case (idx)
      `IOSD_PORT_A_PIN_INPUT, `IOSD_PORT_B_PIN_INPUT, `IOSD_PORT_C_PIN_INPUT,
      `IOSD_PORT_D_PIN_INPUT, `IOSD_PORT_E_PIN_INPUT, `IOSD_PORT_F_PIN_INPUT,
      `IOSD_PORT_G_PIN_INPUT:
        k = IOSD_K_RO;
      `IOSD_TIMER0_IRQ_FLAGS, `IOSD_TIMER1_IRQ_FLAGS, `IOSD_TIMER2_IRQ_FLAGS,
      `IOSD_EXT_IRQ_FLAGS:
        k = IOSD_K_W1C;
      `IOSD_PORT_A_DIRECTION, `IOSD_PORT_A_OUTPUT, `IOSD_PORT_B_DIRECTION,
      `IOSD_PORT_B_OUTPUT, `IOSD_PORT_C_DIRECTION, `IOSD_PORT_C_OUTPUT,
      `IOSD_PORT_D_DIRECTION, `IOSD_PORT_D_OUTPUT, `IOSD_PORT_E_DIRECTION,
      `IOSD_PORT_E_OUTPUT, `IOSD_PORT_F_DIRECTION, `IOSD_PORT_F_OUTPUT,
      `IOSD_PORT_G_DIRECTION, `IOSD_PORT_G_OUTPUT, `IOSD_EXT_IRQ_MASK,
      `IOSD_SCRATCH_BYTE_0, `IOSD_NVM_CONTROL, `IOSD_NVM_DATA,
      `IOSD_NVM_ADDRESS_LOW, `IOSD_NVM_ADDRESS_HIGH,
      `IOSD_TIMER_PRESCALER_SYNC_CTRL, `IOSD_TIMER0_CONTROL, `IOSD_TIMER0_COUNT:
        k = IOSD_K_RW;
      default:
        k = IOSD_K_NONE;
    endcase
    return k;
  endfunction

  // reserved bits and addresses read zero through these masks
  function automatic logic [7:0] entry_mask(input logic [5:0] idx);
    logic [7:0] m;
    m = `IOSD_MASK_FULL;
    unique case (idx)
      `IOSD_PORT_G_PIN_INPUT: m = `IOSD_MASK_PORT_G_PIN;
      `IOSD_PORT_G_DIRECTION, `IOSD_PORT_G_OUTPUT: m = `IOSD_MASK_PORT_G;
      `IOSD_TIMER0_IRQ_FLAGS: m = `IOSD_MASK_TIMER0_FLAGS;
      `IOSD_TIMER1_IRQ_FLAGS: m = `IOSD_MASK_TIMER1_FLAGS;
      `IOSD_TIMER2_IRQ_FLAGS: m = `IOSD_MASK_TIMER2_FLAGS;
      `IOSD_EXT_IRQ_FLAGS, `IOSD_EXT_IRQ_MASK: m = `IOSD_MASK_EXT_IRQ;
      `IOSD_NVM_CONTROL: m = `IOSD_MASK_NVM_CONTROL;
      `IOSD_NVM_ADDRESS_HIGH: m = `IOSD_MASK_NVM_ADDR_HIGH;
      `IOSD_TIMER_PRESCALER_SYNC_CTRL: m = `IOSD_MASK_PRESCALER;
      `IOSD_TIMER0_CONTROL: m = `IOSD_MASK_TIMER0_CTRL;
      default: m = `IOSD_MASK_FULL;
    endcase
    if (entry_kind(idx) == IOSD_K_NONE)
    begin
      m = 8'h00;
    end
    return m;
  endfunction

  // ========================================================================
  // pin synchronisers
  logic [6:0][7:0] pin_s1_q;
  logic [6:0][7:0] pin_s2_q;

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= PIN_IN;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ========================================================================
  // request decode
  iosd_state_t state_q;
  logic active;
  logic bad;
  logic hit_ext;
  logic hit_low;
  logic is_rd;
  logic is_wr;
  logic is_bit_wr;
  logic is_test;
  logic [5:0] io_idx;
  logic [7:0] io_full;
  logic [7:0] wr_mask;
  logic [7:0] wr_val;

  assign active = (REQ.op != IOSD_OP_IDLE) && (state_q == IOSD_ST_IDLE);

  always_comb
  begin
    io_full = 8'h00;
    bad = 1'b0;
    hit_ext = 1'b0;
    is_rd = 1'b0;
    is_wr = 1'b0;
    is_bit_wr = 1'b0;
    is_test = 1'b0;
    unique case (REQ.op)
      IOSD_OP_IDLE:
      begin
        io_full = 8'h00;
      end
      IOSD_OP_IO_IN, IOSD_OP_IO_OUT:
      begin
        io_full = REQ.addr;
        bad = (REQ.addr > `IOSD_IO_TOP);
        is_rd = (REQ.op == IOSD_OP_IO_IN);
        is_wr = (REQ.op == IOSD_OP_IO_OUT);
      end
      IOSD_OP_SET_IO_BIT, IOSD_OP_CLEAR_IO_BIT:
      begin
        io_full = REQ.addr;
        bad = (REQ.addr > `IOSD_BIT_TOP);
        is_bit_wr = 1'b1;
      end
      IOSD_OP_SKIP_IF_IO_BIT_SET, IOSD_OP_SKIP_IF_IO_BIT_CLEAR:
      begin
        io_full = REQ.addr;
        bad = (REQ.addr > `IOSD_BIT_TOP);
        is_test = 1'b1;
      end
      IOSD_OP_DATA_LOAD, IOSD_OP_DATA_STORE:
      begin
        is_rd = (REQ.op == IOSD_OP_DATA_LOAD);
        is_wr = (REQ.op == IOSD_OP_DATA_STORE);
        if (REQ.addr >= `IOSD_EXT_LO)
        begin
          hit_ext = 1'b1;
        end
        else if (REQ.addr >= `IOSD_DATA_OFS)
        begin
          io_full = REQ.addr - `IOSD_DATA_OFS;
        end
        else
        begin
          bad = 1'b1;
        end
      end
      default:
      begin
        bad = 1'b1;
      end
    endcase
  end

  assign io_idx = io_full[5:0];
  assign hit_low = active && !bad && !hit_ext && (io_idx < `IOSD_NREG);

  // bit ops write a one-hot mask so neighbouring flags stay put
  always_comb
  begin
    wr_mask = `IOSD_MASK_FULL;
    wr_val = REQ.wdata;
    if (is_bit_wr)
    begin
      wr_mask = 8'h01 << REQ.bitsel;
      wr_val = (REQ.op == IOSD_OP_SET_IO_BIT) ? wr_mask : 8'h00;
    end
  end

  // ========================================================================
  // register storage, one entry per io location below 0x27
  logic [7:0] mem_q [`IOSD_NREG];
  logic [7:0] mem_d [`IOSD_NREG];
  logic [7:0] rd_val [`IOSD_NREG];
  logic [7:0] hw_set [`IOSD_NREG];

  generate
    for (genvar i = 0; i < `IOSD_NREG; i++)
    begin : g_entry
      localparam logic [5:0] IDX = 6'(i);
      localparam iosd_kind_t KIND = entry_kind(IDX);
      localparam logic [7:0] MASK = entry_mask(IDX);
      logic we;

      // reserved locations see the write strobe, but their zero mask keeps the stored value at zero
      assign we = hit_low && (io_idx == IDX) && (is_wr || is_bit_wr);

      always_comb
      begin
        hw_set[i] = 8'h00;
        if (IDX == `IOSD_TIMER0_IRQ_FLAGS)
        begin
          hw_set[i] = TMR_FLAG_SET[0];
        end
        else if (IDX == `IOSD_TIMER1_IRQ_FLAGS)
        begin
          hw_set[i] = TMR_FLAG_SET[1];
        end
        else if (IDX == `IOSD_TIMER2_IRQ_FLAGS)
        begin
          hw_set[i] = TMR_FLAG_SET[2];
        end
        else if (IDX == `IOSD_EXT_IRQ_FLAGS)
        begin
          hw_set[i] = EXT_FLAG_SET;
        end
      end

      always_comb
      begin
        mem_d[i] = mem_q[i];
        if (we && (KIND == IOSD_K_RW))
        begin
          mem_d[i] = (mem_q[i] & ~wr_mask) | (wr_val & wr_mask);
        end
        if (we && (KIND == IOSD_K_W1C))
        begin
          mem_d[i] = mem_q[i] & ~(wr_val & wr_mask);
        end
        // a flag raised in the clearing cycle survives the clear
        if (KIND == IOSD_K_W1C)
        begin
          mem_d[i] = mem_d[i] | hw_set[i];
        end
        mem_d[i] = (KIND == IOSD_K_RO) ? 8'h00 : (mem_d[i] & MASK);
      end

      always_ff @(posedge MCLK)
      begin
        if (!RST_N)
        begin
          mem_q[i] <= `IOSD_RESET_VAL;
        end
        else
        begin
          mem_q[i] <= mem_d[i];
        end
      end

      // pin inputs read the synchronised pads, writes to them are dropped
      if (KIND == IOSD_K_RO)
      begin : g_pin
        assign rd_val[i] = pin_s2_q[i / 3] & MASK;
      end
      else
      begin : g_store
        assign rd_val[i] = mem_q[i] & MASK;
      end
    end
  endgenerate

  // ========================================================================
  // peripheral side outputs
  generate
    for (genvar p = 0; p < 7; p++)
    begin : g_port
      assign DIR_OUT[p] = mem_q[3 * p + 1];
      assign PORT_OUT[p] = mem_q[3 * p + 2];
    end
  endgenerate

  assign TMR_FLAG_OUT[0] = mem_q[`IOSD_TIMER0_IRQ_FLAGS];
  assign TMR_FLAG_OUT[1] = mem_q[`IOSD_TIMER1_IRQ_FLAGS];
  assign TMR_FLAG_OUT[2] = mem_q[`IOSD_TIMER2_IRQ_FLAGS];
  assign EXT_FLAG_OUT = mem_q[`IOSD_EXT_IRQ_FLAGS];
  assign EXT_MASK_OUT = mem_q[`IOSD_EXT_IRQ_MASK];
  assign SCRATCH_OUT = mem_q[`IOSD_SCRATCH_BYTE_0];
  assign NVM_CTRL_OUT = mem_q[`IOSD_NVM_CONTROL];
  assign NVM_DATA_OUT = mem_q[`IOSD_NVM_DATA];
  assign NVM_ADDR_OUT = {mem_q[`IOSD_NVM_ADDRESS_HIGH], mem_q[`IOSD_NVM_ADDRESS_LOW]};
  assign PRESCALE_CTRL_OUT = mem_q[`IOSD_TIMER_PRESCALER_SYNC_CTRL];
  assign T0_CTRL_OUT = mem_q[`IOSD_TIMER0_CONTROL];
  assign T0_COUNT_OUT = mem_q[`IOSD_TIMER0_COUNT];

  // force bit is a strobe: it is never stored and always reads zero
  logic t0_force_q;

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      t0_force_q <= 1'b0;
    end
    else
    begin
      t0_force_q <= hit_low && (is_wr || is_bit_wr)
                    && (io_idx == `IOSD_TIMER0_CONTROL)
                    && wr_mask[`IOSD_TIMER0_FORCE_BIT] && wr_val[`IOSD_TIMER0_FORCE_BIT];
    end
  end

  assign T0_FORCE = t0_force_q;

  // ========================================================================
  // extended space forwarding and wait state
  iosd_ext_t ext_q;

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      state_q <= IOSD_ST_IDLE;
    end
    else
    begin
      unique case (state_q)
        IOSD_ST_IDLE:
        begin
          if (active && hit_ext && is_rd)
          begin
            state_q <= IOSD_ST_EXT_WAIT;
          end
        end
        IOSD_ST_EXT_WAIT:
        begin
          state_q <= IOSD_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      ext_q <= '0;
    end
    else
    begin
      ext_q.we <= active && hit_ext && is_wr;
      ext_q.re <= active && hit_ext && is_rd;
      if (active && hit_ext)
      begin
        ext_q.addr <= REQ.addr;
        ext_q.wdata <= REQ.wdata;
      end
    end
  end

  assign EXT = ext_q;

  // ========================================================================
  // answer to the core
  // extended loads answer one cycle later than io space; busy covers the gap
  iosd_rsp_t rsp_q;
  logic tbit;

  assign tbit = hit_low ? rd_val[io_idx][REQ.bitsel] : 1'b0;

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      rsp_q <= '0;
    end
    else if (state_q == IOSD_ST_EXT_WAIT)
    begin
      rsp_q.valid <= 1'b1;
      rsp_q.err <= 1'b0;
      rsp_q.skip <= 1'b0;
      rsp_q.busy <= 1'b0;
      rsp_q.rdata <= EXT_RDATA;
    end
    else
    begin
      rsp_q.valid <= active && !bad && !(hit_ext && is_rd);
      rsp_q.err <= active && bad;
      rsp_q.busy <= active && hit_ext && is_rd;
      rsp_q.skip <= active && !bad && is_test
                    && ((REQ.op == IOSD_OP_SKIP_IF_IO_BIT_SET) ? tbit : !tbit);
      rsp_q.rdata <= (hit_low && is_rd) ? rd_val[io_idx] : 8'h00;
    end
  end

  assign RSP = rsp_q;

endmodule

//--- inc/iosd_params.svh
`ifndef IOSD_PARAMS_SVH
`define IOSD_PARAMS_SVH

// ==========================================================================
// address space limits
`define IOSD_NREG 6'h27
`define IOSD_IO_TOP 8'h3F
`define IOSD_BIT_TOP 8'h1F
`define IOSD_DATA_OFS 8'h20
`define IOSD_EXT_LO 8'h60
`define IOSD_EXT_HI 8'hFF

// ==========================================================================
// register offsets in io space
`define IOSD_PORT_A_PIN_INPUT 6'h00
`define IOSD_PORT_A_DIRECTION 6'h01
`define IOSD_PORT_A_OUTPUT 6'h02
`define IOSD_PORT_B_PIN_INPUT 6'h03
`define IOSD_PORT_B_DIRECTION 6'h04
`define IOSD_PORT_B_OUTPUT 6'h05
`define IOSD_PORT_C_PIN_INPUT 6'h06
`define IOSD_PORT_C_DIRECTION 6'h07
`define IOSD_PORT_C_OUTPUT 6'h08
`define IOSD_PORT_D_PIN_INPUT 6'h09
`define IOSD_PORT_D_DIRECTION 6'h0a
`define IOSD_PORT_D_OUTPUT 6'h0b
`define IOSD_PORT_E_PIN_INPUT 6'h0c
`define IOSD_PORT_E_DIRECTION 6'h0d
`define IOSD_PORT_E_OUTPUT 6'h0e
`define IOSD_PORT_F_PIN_INPUT 6'h0f
`define IOSD_PORT_F_DIRECTION 6'h10
`define IOSD_PORT_F_OUTPUT 6'h11
`define IOSD_PORT_G_PIN_INPUT 6'h12
`define IOSD_PORT_G_DIRECTION 6'h13
`define IOSD_PORT_G_OUTPUT 6'h14
`define IOSD_TIMER0_IRQ_FLAGS 6'h15
`define IOSD_TIMER1_IRQ_FLAGS 6'h16
`define IOSD_TIMER2_IRQ_FLAGS 6'h17
`define IOSD_EXT_IRQ_FLAGS 6'h1c
`define IOSD_EXT_IRQ_MASK 6'h1d
`define IOSD_SCRATCH_BYTE_0 6'h1e
`define IOSD_NVM_CONTROL 6'h1f
`define IOSD_NVM_DATA 6'h20
`define IOSD_NVM_ADDRESS_LOW 6'h21
`define IOSD_NVM_ADDRESS_HIGH 6'h22
`define IOSD_TIMER_PRESCALER_SYNC_CTRL 6'h23
`define IOSD_TIMER0_CONTROL 6'h24
`define IOSD_TIMER0_COUNT 6'h26

// ==========================================================================
// implemented bits, all registers reset to zero
`define IOSD_RESET_VAL 8'h00
`define IOSD_MASK_FULL 8'hFF
`define IOSD_MASK_PORT_G_PIN 8'h3F
`define IOSD_MASK_PORT_G 8'h1F
`define IOSD_MASK_TIMER0_FLAGS 8'h03
`define IOSD_MASK_TIMER1_FLAGS 8'h27
`define IOSD_MASK_TIMER2_FLAGS 8'h03
`define IOSD_MASK_EXT_IRQ 8'hF1
`define IOSD_MASK_NVM_CONTROL 8'h0F
`define IOSD_MASK_NVM_ADDR_HIGH 8'h03
`define IOSD_MASK_PRESCALER 8'h83
`define IOSD_MASK_TIMER0_CTRL 8'h7F
`define IOSD_TIMER0_FORCE_BIT 3'h7

`endif

//--- inc/iosd_pkg.sv
package iosd_pkg;

  // ========================================================================
  // access kinds of one io location
  typedef enum logic [1:0] {
    IOSD_K_NONE = 2'h0,
    IOSD_K_RO = 2'h1,
    IOSD_K_RW = 2'h2,
    IOSD_K_W1C = 2'h3
  } iosd_kind_t;

  // ========================================================================
  // core access operations
  typedef enum logic [3:0] {
    IOSD_OP_IDLE = 4'h0,
    IOSD_OP_IO_IN = 4'h1,
    IOSD_OP_IO_OUT = 4'h2,
    IOSD_OP_SET_IO_BIT = 4'h3,
    IOSD_OP_CLEAR_IO_BIT = 4'h4,
    IOSD_OP_SKIP_IF_IO_BIT_SET = 4'h5,
    IOSD_OP_SKIP_IF_IO_BIT_CLEAR = 4'h6,
    IOSD_OP_DATA_LOAD = 4'h7,
    IOSD_OP_DATA_STORE = 4'h8
  } iosd_op_t;

  typedef enum logic {
    IOSD_ST_IDLE = 1'b0,
    IOSD_ST_EXT_WAIT = 1'b1
  } iosd_state_t;

  typedef struct packed {
    iosd_op_t op;
    logic [7:0] addr;
    logic [2:0] bitsel;
    logic [7:0] wdata;
  } iosd_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic skip;
    logic busy;
    logic [7:0] rdata;
  } iosd_rsp_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iosd_ext_t;

endpackage

//--- verif/iosd_assertions.sv
`timescale 1ns/100ps
// ==========================================================================
// port checks for the io decoder
module iosd_assertions
  import iosd_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input iosd_req_t REQ,
  input iosd_rsp_t RSP,
  input iosd_ext_t EXT,
  input wire logic [7:0] EXT_RDATA,
  input wire logic [6:0][7:0] PORT_OUT,
  input wire logic [2:0][7:0] TMR_FLAG_SET,
  input wire logic [2:0][7:0] TMR_FLAG_OUT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  logic tk;
  logic bit_op;
  // requests during busy are dropped, so they must not trigger checks
  assign tk = (REQ.op != IOSD_OP_IDLE) && !RSP.busy;
  assign bit_op = REQ.op inside {IOSD_OP_SET_IO_BIT, IOSD_OP_CLEAR_IO_BIT,
    IOSD_OP_SKIP_IF_IO_BIT_SET, IOSD_OP_SKIP_IF_IO_BIT_CLEAR};

  bit_range_a: assert property (tk && bit_op && REQ.addr > 8'h1F |=> RSP.err && !RSP.valid)
    else $error("bit op above 0x1F not refused");
  io_range_a: assert property (tk && REQ.op inside {IOSD_OP_IO_IN, IOSD_OP_IO_OUT}
    && REQ.addr > 8'h3F |=> RSP.err)
    else $error("in or out above 0x3F not refused");
  ext_fwd_a: assert property (tk && REQ.op == IOSD_OP_DATA_STORE && REQ.addr >= 8'h60
    |=> EXT.we && EXT.wdata == $past(REQ.wdata) && EXT.addr == $past(REQ.addr))
    else $error("extended store not forwarded");
  ext_read_a: assert property (EXT.re |-> RSP.busy ##1 RSP.valid && RSP.rdata == $past(EXT_RDATA))
    else $error("extended load data not returned");
  bit_set_a: assert property (tk && REQ.op == IOSD_OP_SET_IO_BIT && REQ.addr == 8'h05
    |=> PORT_OUT[1] == ($past(PORT_OUT[1]) | (8'h01 << $past(REQ.bitsel))))
    else $error("bit set disturbed other bits");
  data_alias_a: assert property (tk && REQ.op == IOSD_OP_DATA_STORE && REQ.addr == 8'h25
    |=> PORT_OUT[1] == $past(REQ.wdata))
    else $error("data space store missed io register");
  w1c_keep_a: assert property (tk && REQ.op == IOSD_OP_IO_OUT && REQ.addr == 8'h15
    && REQ.wdata == 8'h00 && TMR_FLAG_SET[0] == 8'h00 |=> $stable(TMR_FLAG_OUT[0]))
    else $error("zero write changed flags");
  w1c_clear_a: assert property (tk && REQ.op == IOSD_OP_IO_OUT && REQ.addr == 8'h15
    && (REQ.wdata & 8'h03) == 8'h03 && TMR_FLAG_SET[0] == 8'h00 |=> TMR_FLAG_OUT[0] == 8'h00)
    else $error("ones write left flags set");
  rsvd_read_a: assert property (tk && REQ.op == IOSD_OP_IO_IN && REQ.addr == 8'h25
    |=> RSP.valid && RSP.rdata == 8'h00)
    else $error("reserved address read nonzero");
  skip_valid_a: assert property (RSP.skip |-> RSP.valid && !RSP.err)
    else $error("skip without valid answer");

  cover property (EXT.re ##1 RSP.valid);
  cover property (RSP.skip);
  cover property (RSP.err);
endmodule

//--- verif/iosd_ext_mem.sv
`timescale 1ns/100ps
// ==========================================================================
// extended io space behind the decoder
module iosd_ext_mem
  import iosd_pkg::*;
(
  input wire logic MCLK,
  input iosd_ext_t EXT,
  output logic [7:0] EXT_RDATA
);
  logic [7:0] mem_q [256];
  logic [7:0] last_q = 8'h00;
  always_ff @(posedge MCLK)
  begin
    if (EXT.we)
      mem_q[EXT.addr] <= EXT.wdata;
    if (EXT.re)
      last_q <= mem_q[EXT.addr];
  end
  // inverted outside a read so a mistimed sample cannot match by luck
  assign EXT_RDATA = EXT.re ? mem_q[EXT.addr] : ~last_q;
endmodule

//--- verif/testbench.sv
`timescale 1ns/100ps
module testbench
  import iosd_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  iosd_req_t req = '0;
  iosd_rsp_t rsp;
  iosd_rsp_t r;
  iosd_ext_t ext;
  logic [7:0] ext_rdata;
  logic [6:0][7:0] pin_in = '0;
  logic [6:0][7:0] port_out;
  logic [6:0][7:0] dir_out;
  logic [2:0][7:0] tmr_set = '0;
  logic [2:0][7:0] tmr_out;
  logic [7:0] eflag_set = 8'h00;
  wire [9:0][7:0] so;
  wire t0_force;
  logic [7:0] m [64] = '{default: 8'h00};
  logic [7:0] v;
  logic [7:0] t;
  logic [7:0] bm;
  logic [2:0] b;
  int n_errors = 0;
  int num_checks = 0;

  iosd_decoder dut (
    .MCLK(mclk),
    .RST_N(rst_n),
    .REQ(req),
    .RSP(rsp),
    .EXT(ext),
    .EXT_RDATA(ext_rdata),
    .PIN_IN(pin_in),
    .PORT_OUT(port_out),
    .DIR_OUT(dir_out),
    .TMR_FLAG_SET(tmr_set),
    .EXT_FLAG_SET(eflag_set),
    .TMR_FLAG_OUT(tmr_out),
    .EXT_FLAG_OUT(so[0]), .EXT_MASK_OUT(so[1]), .SCRATCH_OUT(so[2]), .NVM_CTRL_OUT(so[3]),
    .NVM_DATA_OUT(so[4]), .NVM_ADDR_OUT(so[6:5]), .PRESCALE_CTRL_OUT(so[7]),
    .T0_CTRL_OUT(so[8]), .T0_FORCE(t0_force), .T0_COUNT_OUT(so[9])
  );
  iosd_ext_mem u_ext (.MCLK(mclk), .EXT(ext), .EXT_RDATA(ext_rdata));

  // ========================================================================
  // reference model of the io map
  function automatic logic [7:0] msk(int a);
    case (a)
      'h12: return 8'h3F;
      'h13, 'h14: return 8'h1F;
      'h15, 'h17, 'h22: return 8'h03;
      'h16: return 8'h27;
      'h1C, 'h1D: return 8'hF1;
      'h1F: return 8'h0F;
      'h23: return 8'h83;
      'h24: return 8'h7F;
      'h18, 'h19, 'h1A, 'h1B, 'h25: return 8'h00;
      default: return (a < 'h27) ? 8'hFF : 8'h00;
    endcase
  endfunction
  function automatic bit ro(int a);
    return a < 'h15 && a % 3 == 0;
  endfunction
  function automatic bit w1c(int a);
    return a inside {'h15, 'h16, 'h17, 'h1C};
  endfunction
  function automatic logic [7:0] mrd(int a);
    return ro(a) ? pin_in[a / 3] & msk(a) : m[a];
  endfunction
  function automatic void mwr(int a, logic [7:0] w);
    if (w1c(a))
      m[a] = m[a] & ~w;
    else if (!ro(a))
      m[a] = w & msk(a);
  endfunction

  // ========================================================================
  // core side access and compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xf(input iosd_op_t o, input logic [7:0] a, input logic [2:0] bs,
    input logic [7:0] w);
    @(posedge mclk);
    req <= '{o, a, bs, w};
    @(posedge mclk);
    req.op <= IOSD_OP_IDLE;
    #1;
    if (rsp.busy)
    begin
      @(posedge mclk);
      #1;
    end
    r = rsp;
  endtask
  task automatic rd(input int a);
    xf(IOSD_OP_IO_IN, 8'(a), 3'h0, 8'h00);
    chk(r.rdata, mrd(a));
    chk(8'({r.err, r.valid}), 8'h01);
    xf(IOSD_OP_DATA_LOAD, 8'(a + 'h20), 3'h0, 8'h00);
    chk(r.rdata, mrd(a));
  endtask
  task automatic flags();
    @(posedge mclk);
    tmr_set <= '1;
    eflag_set <= 8'hFF;
    @(posedge mclk);
    tmr_set <= '0;
    eflag_set <= 8'h00;
    m['h15] = 8'h03;
    m['h16] = 8'h27;
    m['h17] = 8'h03;
    m['h1C] = 8'hF1;
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    forever #50 mclk = ~mclk;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    give_verdict();
  end

  initial
  begin
    void'($urandom(19193));
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    pin_in <= 56'({$urandom(), $urandom()});
    repeat (3) @(posedge mclk);
    // reset values, then writes alternating io and data space
    for (int a = 0; a < 64; a++)
    begin
      rd(a);
      v = 8'($urandom()) & msk(a);
      if (msk(a) == 8'h00)
        v = 8'h00;
      else if (a % 2)
        xf(IOSD_OP_DATA_STORE, 8'(a + 'h20), 3'h0, v);
      else
        xf(IOSD_OP_IO_OUT, 8'(a), 3'h0, v);
      mwr(a, v);
      rd(a);
    end
    for (int p = 0; p < 7; p++)
    begin
      chk(port_out[p], m[3 * p + 2]);
      chk(dir_out[p], m[3 * p + 1]);
    end
    for (int i = 0; i < 10; i++)
      chk(so[i], m[(i < 9) ? 'h1C + i : 'h26]);
    // force strobe pulses once and is never stored
    xf(IOSD_OP_IO_OUT, 8'h24, 3'h0, 8'h80);
    chk(8'(t0_force), 8'h01);
    mwr('h24, 8'h80);
    chk(so[8], m['h24]);
    // single bit set, clear and skip tests with pending flags
    flags();
    for (int a = 0; a < 32; a++)
      for (int k = 0; k < 2; k++)
      begin
        do
          b = 3'($urandom());
        while (msk(a) != 8'h00 && (msk(a) & (8'h01 << b)) == 8'h00);
        bm = 8'h01 << b;
        if (msk(a) != 8'h00)
          xf(k ? IOSD_OP_CLEAR_IO_BIT : IOSD_OP_SET_IO_BIT, 8'(a), b, 8'h00);
        if (w1c(a))
          m[a] = k ? m[a] : m[a] & ~bm;
        else if (!ro(a))
          m[a] = (k ? m[a] & ~bm : m[a] | bm) & msk(a);
        t = mrd(a);
        xf(k ? IOSD_OP_SKIP_IF_IO_BIT_CLEAR : IOSD_OP_SKIP_IF_IO_BIT_SET, 8'(a), b, 8'h00);
        chk(8'(r.skip), 8'(t[b] ^ k[0]));
        rd(a);
      end
    // flag writes: zero keeps, one clears
    flags();
    for (int k = 0; k < 2; k++)
    begin
      v = k ? 8'h03 : 8'h00;
      xf(IOSD_OP_IO_OUT, 8'h15, 3'h0, v);
      mwr('h15, v);
      chk(tmr_out[0], m['h15]);
    end
    // refused accesses outside each path's range
    for (int k = 0; k < 4; k++)
    begin
      xf(k[0] ? IOSD_OP_IO_OUT : IOSD_OP_SET_IO_BIT, k[1] ? 8'h60 : 8'h40, 3'h1, 8'hFF);
      chk(8'({r.err, r.valid}), 8'h02);
    end
    for (int k = 0; k < 2; k++)
    begin
      xf(k ? IOSD_OP_SKIP_IF_IO_BIT_CLEAR : IOSD_OP_SKIP_IF_IO_BIT_SET, 8'h20, 3'h0, 8'h00);
      chk(8'({r.err, r.valid, r.skip}), 8'h04);
    end
    xf(IOSD_OP_DATA_LOAD, 8'h1F, 3'h0, 8'h00);
    chk(8'({r.err, r.valid}), 8'h02);
    rd('h20);
    // extended space through load and store, both ends of the range
    for (int k = 0; k < 4; k++)
    begin
      t = (k == 0) ? 8'h60 : (k == 1) ? 8'hFF : 8'($urandom_range(255, 96));
      v = 8'($urandom());
      xf(IOSD_OP_DATA_STORE, t, 3'h0, v);
      xf(IOSD_OP_DATA_LOAD, t, 3'h0, 8'h00);
      chk(r.rdata, v);
    end
    give_verdict();
  end
endmodule

bind iosd_decoder iosd_assertions u_chk (
  .MCLK(MCLK),
  .RST_N(RST_N),
  .REQ(REQ),
  .RSP(RSP),
  .EXT(EXT),
  .EXT_RDATA(EXT_RDATA),
  .PORT_OUT(PORT_OUT),
  .TMR_FLAG_SET(TMR_FLAG_SET),
  .TMR_FLAG_OUT(TMR_FLAG_OUT)
);
